// [include/dpmf_pkg.sv]
// Package of sizes, field positions and reset values for the dual-port mailbox block
package dpmf_pkg;

  // ==========================================================================
  // Mailbox geometry
  localparam int unsigned DPMF_MB_COUNT = 4;
  localparam int unsigned DPMF_BYTES = 4;
  localparam int unsigned DPMF_DATA_W = 32;
  localparam int unsigned DPMF_IDX_W = 2;
  localparam int unsigned DPMF_FLAG_W = 16;
  localparam int unsigned DPMF_STATUS_W = 32;
  localparam int unsigned DPMF_SRC_SEL_W = 4;

  // ==========================================================================
  // Status register layout: bus outgoing (local incoming) flags low half, bus incoming (local outgoing) flags high half
  localparam int unsigned DPMF_OUT_FLAG_LSB = 0;
  localparam int unsigned DPMF_IN_FLAG_LSB = 16;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] DPMF_DATA_RST = 32'h0000_0000;
  localparam logic [15:0] DPMF_FLAG_RST = 16'h0000;
  localparam logic [31:0] DPMF_RDATA_RST = 32'h0000_0000;

  typedef logic [31:0] dpmf_word_t;
  typedef logic [15:0] dpmf_flags_t;

endpackage

// [hw/dpmf_mailbox.sv]
// Dual-port mailbox block with per-byte full flags and mailbox interrupts
// Function
// R1: Eight 32-bit mailbox words carry command and status between the bus side and the local side.
// R2: Each side sees four incoming and four outgoing mailboxes.
// R3: Bus incoming n is local outgoing n and local incoming n is bus outgoing n, one storage word each.
// R4: Each side has its own status word with one full flag per byte of all eight mailboxes.
// R5: Each side picks one incoming and one outgoing mailbox byte as interrupt sources on its own.
// R6: Local reads of an incoming mailbox return a word held in an output latch.
// R7: Bus reads of an incoming mailbox return a word held in an interlock latch.
// R8: A write to an outgoing mailbox sets full flags only for the enabled bytes.
// R9: An outgoing write stores into the shared word and sets the flags seen on both sides.
// R10: A read of incoming bytes clears their full flags on both sides.
// R11: Mailbox m byte b has its flag at bit 4*(m-1)+b.
// R12: Status words are read-only and either side can clear all full flags at once.
// R13: Writing a full mailbox overwrites it and reading an empty one returns old data, with no retry.
// R14: A burst request to the mailboxes is answered with disconnect-with-data after one data phase.
// R15: An enabled incoming-full interrupt asserts on the clock edge after the other side's write.
// R16: Reset empties every flag and leaves no interrupt pending.
// R17: Local accesses are synchronous to the buffered bus clock.
module dpmf_mailbox
  import dpmf_pkg::*;
(
  input wire logic core_clk_i, // Bus clock, also the buffered local clock
  input wire logic rst_i, // Asynchronous reset, active high
  // Bus side access
  input wire logic pci_req_i, // Access request, one data phase
  input wire logic pci_we_i, // 1 write, 0 read
  input wire logic pci_in_sel_i, // 1 incoming mailbox, 0 outgoing
  input wire logic [1:0] pci_idx_i, // Mailbox number minus one
  input wire logic [3:0] pci_be_i, // Byte enables, active high
  input wire logic [31:0] pci_wdata_i, // Write data
  input wire logic pci_burst_i, // Initiator wants further data phases
  input wire logic pci_flag_clr_all_i, // Clear every full flag
  input wire logic pci_irq_in_en_i, // Incoming-full interrupt enable
  input wire logic [3:0] pci_irq_in_sel_i, // {mailbox, byte} incoming source
  input wire logic pci_irq_out_en_i, // Outgoing-empty interrupt enable
  input wire logic [3:0] pci_irq_out_sel_i, // {mailbox, byte} outgoing source
  input wire logic pci_irq_clr_i, // Software clears pending interrupt
  output logic pci_ack_o, // Data phase taken this cycle
  output logic pci_disconnect_o, // Disconnect with data on this phase
  output logic [31:0] pci_rdata_o, // Latched read data
  output logic [31:0] pci_side_mailbox_flag_status_o, // Bus side status word
  output logic pci_irq_o, // Bus interrupt, active high
  // Local side access
  input wire logic local_req_i, // Access request
  input wire logic local_we_i, // 1 write, 0 read
  input wire logic local_in_sel_i, // 1 incoming mailbox, 0 outgoing
  input wire logic [1:0] local_idx_i, // Mailbox number minus one
  input wire logic [3:0] local_be_i, // Byte enables, active high
  input wire logic [31:0] local_wdata_i, // Write data
  input wire logic local_flag_clr_all_i, // Clear every full flag
  input wire logic local_irq_in_en_i, // Incoming-full interrupt enable
  input wire logic [3:0] local_irq_in_sel_i, // {mailbox, byte} incoming source
  input wire logic local_irq_out_en_i, // Outgoing-empty interrupt enable
  input wire logic [3:0] local_irq_out_sel_i, // {mailbox, byte} outgoing source
  input wire logic local_irq_clr_i, // Software clears pending interrupt
  output logic local_ack_o, // Access taken this cycle
  output logic [31:0] local_rdata_o, // Latched read data
  output logic [31:0] local_side_mailbox_flag_status_o, // Local side status word
  output logic local_irq_o // Local interrupt, active high
);

  // ==========================================================================
  // Helpers
  function automatic dpmf_flags_t byte_mask(input logic [1:0] idx, input logic [3:0] be);
    dpmf_flags_t m;
    m = {12'h000, be};
    return dpmf_flags_t'(m << {idx, 2'b00}); // R11
  endfunction

  // ==========================================================================
  // Storage and flags
  dpmf_word_t p2a_mb [DPMF_MB_COUNT]; // Bus outgoing = local incoming
  dpmf_word_t a2p_mb [DPMF_MB_COUNT]; // Local outgoing = bus incoming
  dpmf_word_t next_p2a_mb [DPMF_MB_COUNT];
  dpmf_word_t next_a2p_mb [DPMF_MB_COUNT];
  dpmf_flags_t p2a_full;
  dpmf_flags_t a2p_full;
  dpmf_flags_t next_p2a_full;
  dpmf_flags_t next_a2p_full;
  dpmf_word_t pci_rdata;
  dpmf_word_t local_rdata;
  dpmf_word_t next_pci_rdata;
  dpmf_word_t next_local_rdata;
  logic pci_irq_pend;
  logic local_irq_pend;
  logic next_pci_irq_pend;
  logic next_local_irq_pend;

  logic pci_wr_out;
  logic pci_rd_in;
  logic local_wr_out;
  logic local_rd_in;
  logic clr_all;
  logic pci_evt;
  logic local_evt;

  assign pci_wr_out = pci_req_i & pci_we_i & ~pci_in_sel_i; // R2
  assign pci_rd_in = pci_req_i & ~pci_we_i & pci_in_sel_i;
  assign local_wr_out = local_req_i & local_we_i & ~local_in_sel_i;
  assign local_rd_in = local_req_i & ~local_we_i & local_in_sel_i;
  assign clr_all = pci_flag_clr_all_i | local_flag_clr_all_i; // R12

  // Every access completes in its own cycle; no retry or abort exists
  assign pci_ack_o = pci_req_i; // R13
  assign local_ack_o = local_req_i; // R13 R17
  assign pci_disconnect_o = pci_req_i & pci_burst_i; // R14

  // ==========================================================================
  // Mailbox data and read latches
  always_comb begin
    next_p2a_mb = p2a_mb;
    next_a2p_mb = a2p_mb;
    next_pci_rdata = pci_rdata;
    next_local_rdata = local_rdata;
    // Reads capture the word before any same-cycle write from the far side
    if (pci_req_i && !pci_we_i) begin
      next_pci_rdata = pci_in_sel_i ? a2p_mb[pci_idx_i] : p2a_mb[pci_idx_i]; // R7 R13
    end
    if (local_req_i && !local_we_i) begin
      next_local_rdata = local_in_sel_i ? p2a_mb[local_idx_i] : a2p_mb[local_idx_i]; // R6 R13
    end
    // Writes to incoming mailboxes are ignored: those are read-only
    for (int b = 0; b < DPMF_BYTES; b++) begin
      if (pci_wr_out && pci_be_i[b]) begin
        next_p2a_mb[pci_idx_i][b*8 +: 8] = pci_wdata_i[b*8 +: 8]; // R3 R9
      end
      if (local_wr_out && local_be_i[b]) begin
        next_a2p_mb[local_idx_i][b*8 +: 8] = local_wdata_i[b*8 +: 8]; // R3 R9
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int m = 0; m < DPMF_MB_COUNT; m++) begin
        p2a_mb[m] <= DPMF_DATA_RST;
        a2p_mb[m] <= DPMF_DATA_RST;
      end
      pci_rdata <= DPMF_RDATA_RST;
      local_rdata <= DPMF_RDATA_RST;
    end else begin
      p2a_mb <= next_p2a_mb; // R1
      a2p_mb <= next_a2p_mb; // R1
      pci_rdata <= next_pci_rdata;
      local_rdata <= next_local_rdata;
    end
  end

  // ==========================================================================
  // Full flags: clears first, then sets, so a set in the same cycle wins
  always_comb begin
    next_p2a_full = p2a_full;
    next_a2p_full = a2p_full;
    if (clr_all) begin
      next_p2a_full = DPMF_FLAG_RST; // R12
      next_a2p_full = DPMF_FLAG_RST; // R12
    end
    if (local_rd_in) begin
      next_p2a_full = next_p2a_full & ~byte_mask(local_idx_i, local_be_i); // R10
    end
    if (pci_rd_in) begin
      next_a2p_full = next_a2p_full & ~byte_mask(pci_idx_i, pci_be_i); // R10
    end
    if (pci_wr_out) begin
      next_p2a_full = next_p2a_full | byte_mask(pci_idx_i, pci_be_i); // R8 R9
    end
    if (local_wr_out) begin
      next_a2p_full = next_a2p_full | byte_mask(local_idx_i, local_be_i); // R8 R9
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      p2a_full <= DPMF_FLAG_RST; // R16
      a2p_full <= DPMF_FLAG_RST; // R16
    end else begin
      p2a_full <= next_p2a_full;
      a2p_full <= next_a2p_full;
    end
  end

  // Bus word: outgoing low, incoming high; local word: incoming low, outgoing high,
  // so a mailbox byte sits at the same bit in both words
  assign pci_side_mailbox_flag_status_o = {a2p_full, p2a_full}; // R4 R11 R12
  assign local_side_mailbox_flag_status_o = {a2p_full, p2a_full}; // R4 R11 R12

  // ==========================================================================
  // Interrupts: incoming byte becoming full, outgoing byte becoming empty
  always_comb begin
    pci_evt = 1'b0;
    local_evt = 1'b0;
    if (pci_irq_in_en_i && next_a2p_full[pci_irq_in_sel_i] && !a2p_full[pci_irq_in_sel_i]) begin
      pci_evt = 1'b1; // R5 R15
    end
    if (pci_irq_out_en_i && p2a_full[pci_irq_out_sel_i] && !next_p2a_full[pci_irq_out_sel_i]) begin
      pci_evt = 1'b1; // R5
    end
    if (local_irq_in_en_i && next_p2a_full[local_irq_in_sel_i] && !p2a_full[local_irq_in_sel_i]) begin
      local_evt = 1'b1; // R5
    end
    if (local_irq_out_en_i && a2p_full[local_irq_out_sel_i] && !next_a2p_full[local_irq_out_sel_i]) begin
      local_evt = 1'b1; // R5
    end
    // A new event outranks a clear in the same cycle
    next_pci_irq_pend = pci_evt | (pci_irq_pend & ~pci_irq_clr_i);
    next_local_irq_pend = local_evt | (local_irq_pend & ~local_irq_clr_i);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pci_irq_pend <= 1'b0; // R16
      local_irq_pend <= 1'b0; // R16
    end else begin
      pci_irq_pend <= next_pci_irq_pend; // R15
      local_irq_pend <= next_local_irq_pend;
    end
  end

  assign pci_irq_o = pci_irq_pend;
  assign local_irq_o = local_irq_pend;
  assign pci_rdata_o = pci_rdata;
  assign local_rdata_o = local_rdata;

endmodule

// [test/dpmf_mailbox_properties.sv]
// Checker of mailbox flag, read latch, burst and interrupt timing at the block ports
module dpmf_mailbox_properties
  import dpmf_pkg::*;
(
  input wire logic core_clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic pci_req_i, // Bus request
  input wire logic pci_we_i, // Bus write
  input wire logic pci_in_sel_i, // Bus incoming select
  input wire logic [1:0] pci_idx_i, // Bus index
  input wire logic [3:0] pci_be_i, // Bus enables
  input wire logic pci_burst_i, // Bus burst
  input wire logic pci_flag_clr_all_i, // Bus clear-all
  input wire logic pci_irq_in_en_i, // Bus irq enable
  input wire logic [3:0] pci_irq_in_sel_i, // Bus irq source
  input wire logic pci_disconnect_o, // Disconnect
  input wire logic [31:0] pci_side_mailbox_flag_status_o, // Bus flags
  input wire logic pci_irq_o, // Bus irq
  input wire logic local_req_i, // Local request
  input wire logic local_we_i, // Local write
  input wire logic local_in_sel_i, // Local incoming select
  input wire logic [1:0] local_idx_i, // Local index
  input wire logic [3:0] local_be_i, // Local enables
  input wire logic [31:0] local_rdata_o, // Local read data
  input wire logic [31:0] local_side_mailbox_flag_status_o // Local flags
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic [31:0] ps = pci_side_mailbox_flag_status_o;
  wire logic [31:0] ls = local_side_mailbox_flag_status_o;
  // ==========================================================================
  // Properties
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence bus_out_wr;
    pci_req_i && pci_we_i && !pci_in_sel_i;
  endsequence
  sequence loc_in_rd;
    local_req_i && !local_we_i && local_in_sel_i && !(pci_req_i && pci_we_i);
  endsequence
  out_mirror_a: assert property (ps[15:0] == ls[15:0])
    else $error("bus outgoing flags differ from local incoming flags");
  in_mirror_a: assert property (ps[31:16] == ls[31:16])
    else $error("bus incoming flags differ from local outgoing flags");
  burst_disc_a: assert property (pci_disconnect_o == (pci_req_i && pci_burst_i))
    else $error("disconnect does not follow burst request");
  byte_set_a: assert property (bus_out_wr |=> (ps[{$past(pci_idx_i), 2'b00} +: 4] & $past(pci_be_i)) == $past(pci_be_i))
    else $error("enabled bytes not flagged full");
  read_clear_a: assert property (loc_in_rd |=> (ps[{$past(local_idx_i), 2'b00} +: 4] & $past(local_be_i)) == 4'h0)
    else $error("read bytes still flagged full");
  clear_all_a: assert property (pci_flag_clr_all_i && !pci_req_i && !local_req_i |=> ps == 32'h0 && ls == 32'h0)
    else $error("clear-all left flags set");
  in_irq_a: assert property (local_req_i && local_we_i && !local_in_sel_i && pci_irq_in_en_i
    && !ps[{1'b1, pci_irq_in_sel_i}]
    && local_idx_i == pci_irq_in_sel_i[3:2] && local_be_i[pci_irq_in_sel_i[1:0]] |=> pci_irq_o)
    else $error("incoming-full interrupt missing");
  latch_hold_a: assert property (!local_req_i |=> $stable(local_rdata_o))
    else $error("local read data changed without a read");
endmodule
bind dpmf_mailbox dpmf_mailbox_properties u_chk (.*);

// [test/dpmf_addon_model.sv]
// Local add-on bus logic model making mailbox accesses
module dpmf_addon_model (
  input wire logic clk_i, // Buffered bus clock
  output logic req_o, // Request
  output logic we_o, // Write
  output logic in_o, // Incoming select
  output logic [1:0] idx_o, // Mailbox index
  output logic [3:0] be_o, // Byte enables
  output logic [31:0] wd_o // Write data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {req_o, we_o, in_o, idx_o, be_o} = '0;
    wd_o = 32'h5a5a_a5a5;
  end
  // One access, launched and released on falling edges of the bus clock
  task automatic acc(input logic w, i, input logic [1:0] x, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk_i);
    {req_o, we_o, in_o, idx_o, be_o, wd_o} = {1'b1, w, i, x, b, d};
    @(negedge clk_i);
    req_o = 1'b0;
    wd_o = ~d;
  endtask
endmodule

// [test/tb_top.sv]
// Testbench of the dual-port mailbox block
module tb_top
  import dpmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i, rst_i, pci_req_i, pci_we_i, pci_in_sel_i, pci_burst_i, pci_flag_clr_all_i, pci_irq_clr_i;
  logic pci_irq_in_en_i, pci_irq_out_en_i, pci_ack_o, pci_disconnect_o, pci_irq_o, local_req_i, local_we_i;
  logic local_in_sel_i, local_flag_clr_all_i, local_irq_in_en_i, local_irq_out_en_i, local_irq_clr_i;
  logic local_ack_o, local_irq_o;
  logic [1:0] pci_idx_i, local_idx_i;
  logic [3:0] pci_be_i, local_be_i, pci_irq_in_sel_i, pci_irq_out_sel_i, local_irq_in_sel_i, local_irq_out_sel_i;
  logic [31:0] pci_wdata_i, local_wdata_i, pci_rdata_o, local_rdata_o;
  logic [31:0] pci_side_mailbox_flag_status_o, local_side_mailbox_flag_status_o;
  int failures = 0;
  int check_count = 0;
  dpmf_mailbox dut (.*);
  dpmf_addon_model partner (.clk_i(core_clk_i), .req_o(local_req_i), .we_o(local_we_i), .in_o(local_in_sel_i),
    .idx_o(local_idx_i), .be_o(local_be_i), .wd_o(local_wdata_i));
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // ==========================================================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic pacc(input logic w, i, input logic [1:0] x, input logic [3:0] b, input logic [31:0] d);
    @(negedge core_clk_i);
    {pci_req_i, pci_we_i, pci_in_sel_i, pci_idx_i, pci_be_i, pci_wdata_i} = {1'b1, w, i, x, b, d};
    @(negedge core_clk_i);
    pci_req_i = 1'b0;
    pci_wdata_i = ~d;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic sc_walk;
    pacc(1'b1, 1'b0, 2'h1, 4'h3, 32'hcafe_1234);
    chk("bus flags", 32'h0000_0030, pci_side_mailbox_flag_status_o);
    chk("local flags", 32'h0000_0030, local_side_mailbox_flag_status_o);
    chk("local irq", 32'h1, local_irq_o);
    fork
      partner.acc(1'b0, 1'b1, 2'h1, 4'h3, 32'h0);
      begin
        @(negedge core_clk_i);
        #1 chk("local ack", 32'h1, local_ack_o);
      end
    join
    chk("local rdata", 32'h0000_1234, local_rdata_o);
    chk("flags after read", 32'h0, pci_side_mailbox_flag_status_o);
    chk("bus empty irq", 32'h1, pci_irq_o);
  endtask
  task automatic sc_up;
    @(negedge core_clk_i) {pci_irq_clr_i, local_irq_clr_i} = 2'b11;
    @(negedge core_clk_i) {pci_irq_clr_i, local_irq_clr_i} = 2'b00;
    chk("irqs cleared", 32'h0, {pci_irq_o, local_irq_o});
    partner.acc(1'b1, 1'b0, 2'h3, 4'h8, 32'h1111_1111);
    partner.acc(1'b1, 1'b0, 2'h3, 4'h8, 32'h2222_2222);
    chk("bus full irq", 32'h1, pci_irq_o);
    chk("bus flags", 32'h8000_0000, pci_side_mailbox_flag_status_o);
    pacc(1'b0, 1'b1, 2'h3, 4'h8, 32'h0);
    chk("bus rdata", 32'h2200_0000, pci_rdata_o);
    pacc(1'b0, 1'b1, 2'h3, 4'h8, 32'h0);
    chk("empty rdata", 32'h2200_0000, pci_rdata_o);
    chk("flags", 32'h0, local_side_mailbox_flag_status_o);
  endtask
  task automatic sc_burst;
    @(negedge core_clk_i) {pci_req_i, pci_burst_i} = 2'b11;
    #1 chk("disconnect", 32'h1, {pci_ack_o, pci_disconnect_o} == 2'b11);
    @(negedge core_clk_i) {pci_req_i, pci_burst_i} = 2'b00;
  endtask
  task automatic sc_clr;
    pacc(1'b1, 1'b0, 2'h0, 4'hf, 32'h0102_0304);
    partner.acc(1'b1, 1'b0, 2'h2, 4'h1, 32'h0000_00aa);
    chk("both flags", 32'h0100_000f, pci_side_mailbox_flag_status_o);
    @(negedge core_clk_i) pci_flag_clr_all_i = 1'b1;
    @(negedge core_clk_i) pci_flag_clr_all_i = 1'b0;
    chk("cleared", 32'h0, pci_side_mailbox_flag_status_o | local_side_mailbox_flag_status_o);
    chk("local empty irq", 32'h1, local_irq_o);
    pacc(1'b1, 1'b1, 2'h0, 4'hf, 32'hffff_ffff);
    chk("incoming write", 32'h0, pci_side_mailbox_flag_status_o);
    pacc(1'b1, 1'b0, 2'h2, 4'h2, 32'h0000_bb00);
    chk("local incoming flag", 32'h0000_0200, local_side_mailbox_flag_status_o);
    @(negedge core_clk_i) local_flag_clr_all_i = 1'b1;
    @(negedge core_clk_i) local_flag_clr_all_i = 1'b0;
    chk("local cleared", 32'h0, pci_side_mailbox_flag_status_o | local_side_mailbox_flag_status_o);
  endtask
  initial begin
    rst_i = 1'b1;
    {pci_req_i, pci_we_i, pci_in_sel_i, pci_idx_i, pci_be_i, pci_wdata_i, pci_burst_i, pci_flag_clr_all_i} = '0;
    {pci_irq_in_en_i, pci_irq_in_sel_i, pci_irq_out_en_i, pci_irq_out_sel_i, pci_irq_clr_i} = 11'h7e8;
    {local_flag_clr_all_i, local_irq_in_en_i, local_irq_in_sel_i} = 6'h14;
    {local_irq_out_en_i, local_irq_out_sel_i, local_irq_clr_i} = 6'h30;
    repeat (3) @(posedge core_clk_i);
    chk("reset flags", 32'h0, pci_side_mailbox_flag_status_o | local_side_mailbox_flag_status_o);
    @(negedge core_clk_i) rst_i = 1'b0;
    chk("reset irq", 32'h0, {pci_irq_o, local_irq_o});
    sc_walk();
    sc_up();
    sc_burst();
    sc_clr();
    close_out();
  end
endmodule
